// ===== shared/drs_link_if.sv
`timescale 1ns/10ps
// Serial link between host and readback device
interface drs_link_if;
    logic sclk;
    logic sync_n;
    logic sdi;
    logic sdo;

    modport dev (
        input sclk,
        input sync_n,
        input sdi,
        output sdo
    );

    modport host (
        output sclk,
        output sync_n,
        output sdi,
        input sdo
    );
endinterface : drs_link_if

// ===== shared/drs_pkg.sv
// Summary of operation
// - Type in 15:13, channel in 12:7, base 001000
// - Global registers use fixed nine-bit readback codes
// - Payload bits 6:0 never affect readback choice
// - Host sends readback-select frame to start read
// - NOP frame follows; device shifts register out
// - Mode 00: function in 21:16, payload below
// - Code 000101 selects readback; 000000 is NOP
package drs_pkg;
    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 22;
    localparam int FUNC_HI = 21;
    localparam int FUNC_LO = 16;
    localparam int PAY_HI = 15;
    localparam int SEL_LO = 7;
    localparam int TYPE_HI = 15;
    localparam int TYPE_LO = 13;
    localparam int CHAN_HI = 12;
    localparam int CHAN_LO = 7;
    localparam logic [1:0] MODE_SPECIAL = 2'h0;

    // Special function codes
    localparam logic [5:0] FN_NOP = 6'h00;
    localparam logic [5:0] FN_CTRL = 6'h01;
    localparam logic [5:0] FN_OFFSET_ZERO = 6'h02;
    localparam logic [5:0] FN_OFFSET_ONE = 6'h03;
    localparam logic [5:0] FN_READSEL = 6'h05;
    localparam logic [5:0] FN_ABSEL0 = 6'h06;
    localparam logic [5:0] FN_ABSEL3 = 6'h09;
    localparam logic [5:0] FN_ABALL = 6'h0B;
    localparam logic [15:0] NOP_PAYLOAD = 16'h0000;

    // Per-channel register types
    localparam logic [2:0] RB_INPUT_A = 3'h0;
    localparam logic [2:0] RB_INPUT_B = 3'h1;
    localparam logic [2:0] RB_OFFC = 3'h2;
    localparam logic [2:0] RB_GAINC = 3'h3;
    localparam logic [5:0] CHAN_BASE = 6'h08;
    localparam logic [5:0] CHAN_LAST = 6'h27;

    // Global readback codes
    localparam logic [8:0] RB_CTRL = 9'h101;
    localparam logic [8:0] RB_OFFSET_ZERO = 9'h102;
    localparam logic [8:0] RB_OFFSET_ONE = 9'h103;
    localparam logic [8:0] RB_RSVD0 = 9'h104;
    localparam logic [8:0] RB_ABSEL0 = 9'h106;
    localparam logic [8:0] RB_ABSEL3 = 9'h109;
    localparam logic [8:0] RB_RSVD1 = 9'h10A;

    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [13:0] OFS_RST = 14'h0000;
    localparam logic [7:0] ABSEL_RST = 8'h00;

    // Link timing
    localparam int CORE_CLK_NS = 100;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int SYNC_GAP_NS = 400;
    localparam int SYNC_GAP_CYC = (SYNC_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
endpackage : drs_pkg

// ===== verification/dac_register_readback_select_test.sv
`timescale 1ns/10ps
module dac_register_readback_select_test;
    typedef struct packed {
        logic wr;
        logic [23:0] w;
        logic [8:0] code;
        logic [15:0] exp;
    } drs_row_t;

    logic core_clk = 1'b0;
    logic rst;
    logic wr_req = 1'b0;
    logic [23:0] wr_word = 24'h000000;
    logic rd_req = 1'b0;
    logic [8:0] rd_code = 9'h000;
    logic busy, done, rb_pending, rb_chan_ok;
    logic [23:0] rx_word;
    logic [15:0] rd_data, rb_word;
    logic [2:0] rb_type, ctrl_bits;
    logic [4:0] rb_channel;
    logic [13:0] offset_zero, offset_one;
    logic [31:0] absel;
    logic [23:0] mon_in, mon_out, last_in, prev_in, last_out;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    drs_row_t rows [15];

    always #50 core_clk = ~core_clk;

    drs_link_if link ();
    // Channel store stand-in: word tells type and index apart
    assign rb_word = {rb_type, rb_channel, 8'h5A};

    drs_host u_drs_host (.core_clk(core_clk), .rst(rst), .link(link), .wr_req(wr_req),
        .wr_word(wr_word), .rd_req(rd_req), .rd_code(rd_code), .busy(busy), .done(done),
        .rx_word(rx_word), .rd_data(rd_data));
    drs_device u_drs_device (.link(link), .rst(rst), .rb_pending(rb_pending),
        .rb_type(rb_type), .rb_channel(rb_channel), .rb_chan_ok(rb_chan_ok),
        .rb_word(rb_word), .ctrl_bits(ctrl_bits), .offset_zero(offset_zero),
        .offset_one(offset_one), .absel(absel));
    drs_link_props u_drs_link_props (.core_clk(core_clk), .rst(rst), .sclk(link.sclk),
        .sync_n(link.sync_n), .sdi(link.sdi), .sdo(link.sdo));

    // Wire watch: sdi on rises, sdo on falls, frames latched when the strobe ends
    always @(posedge link.sclk) if (!link.sync_n) mon_in <= {mon_in[22:0], link.sdi};
    always @(negedge link.sclk) if (!link.sync_n) mon_out <= {mon_out[22:0], link.sdo};
    always @(posedge link.sync_n) begin
        prev_in <= last_in;
        last_in <= mon_in;
        last_out <= mon_out;
    end

    // Hang guard: whole run needs about 10200 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One host request, then a bounded wait for its done pulse
    task automatic op(input logic rd, input logic [23:0] w, input logic [8:0] code);
        int i;
        @(posedge core_clk);
        rd_req <= rd;
        wr_req <= !rd;
        wr_word <= w;
        rd_code <= code;
        @(posedge core_clk);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        for (i = 0; i < 1000; i++) begin
            @(posedge core_clk);
            #1;
            if (done === 1'b1) break;
        end
        cmp({23'h0, done}, 24'h000001);
    endtask : op

    task automatic rd_chk(input logic [8:0] code, input logic [15:0] exp);
        op(1'b1, 24'h000000, code);
        cmp(prev_in, {drs_pkg::MODE_SPECIAL, drs_pkg::FN_READSEL, code, 7'h00});
        cmp(last_in, 24'h000000);
        cmp({8'h00, rd_data}, {8'h00, exp});
        cmp(last_out, {8'h00, exp});
    endtask : rd_chk

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        // Optional write frame, then the read code and the word it must return
        rows = '{
            '{1'b1, 24'h010005, 9'h101, 16'h0005}, '{1'b1, 24'h02C123, 9'h102, 16'h0123},
            '{1'b1, 24'h033FFF, 9'h103, 16'h3FFF}, '{1'b1, 24'h0600A0, 9'h106, 16'h00A0},
            '{1'b1, 24'h0700A1, 9'h107, 16'h00A1}, '{1'b1, 24'h0800A2, 9'h108, 16'h00A2},
            '{1'b1, 24'h0900A3, 9'h109, 16'h00A3}, '{1'b0, 24'h000000, 9'h104, 16'h0000},
            '{1'b0, 24'h000000, 9'h10A, 16'h0000}, '{1'b0, 24'h000000, 9'h008, 16'h005A},
            '{1'b0, 24'h000000, 9'h048, 16'h205A}, '{1'b0, 24'h000000, 9'h094, 16'h4C5A},
            '{1'b0, 24'h000000, 9'h0E7, 16'h7F5A}, '{1'b0, 24'h000000, 9'h007, 16'h0000},
            '{1'b0, 24'h000000, 9'h0E8, 16'h0000}};
        // Rising edge at time zero: the link-clocked end has no other way to reset
        rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) op(1'b0, rows[i].w, 9'h000);
            rd_chk(rows[i].code, rows[i].exp);
        end
        cmp({21'h0, ctrl_bits}, 24'h000005);
        cmp({10'h0, offset_zero}, 24'h000123);
        // Low payload bits set: selection must still land on the control register
        op(1'b0, {drs_pkg::MODE_SPECIAL, drs_pkg::FN_READSEL, drs_pkg::RB_CTRL,
            7'h7F}, 9'h000);
        op(1'b0, 24'h000000, 9'h000);
        cmp(rx_word, 24'h000005);
        // A second NOP has nothing selected, so it reads back zero
        op(1'b0, 24'h000000, 9'h000);
        cmp(rx_word, 24'h000000);
        // Channel select with low bits set: request must name type 2, channel 12
        op(1'b0, {drs_pkg::MODE_SPECIAL, drs_pkg::FN_READSEL, 9'h094,
            7'h55}, 9'h000);
        cmp({14'h0, rb_pending, rb_chan_ok, rb_type, rb_channel}, 24'h00034C);
        op(1'b0, 24'h000000, 9'h000);
        cmp(rx_word, 24'h004C5A);
        cmp({23'h0, rb_pending}, 24'h000000);
        // Data-write mode frame must leave the control register alone
        op(1'b0, 24'h410007, 9'h000);
        rd_chk(drs_pkg::RB_CTRL, 16'h0005);
        // Block write to all A/B select registers, checked through code 107 only
        op(1'b0, 24'h0B0055, 9'h000);
        rd_chk(9'h107, 16'h0055);
        // Reset in the middle of a read: link falls idle, registers clear
        @(posedge core_clk);
        rd_req <= 1'b1;
        rd_code <= drs_pkg::RB_OFFSET_ZERO;
        @(posedge core_clk);
        rd_req <= 1'b0;
        repeat (100) @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        cmp({18'h0, busy, link.sync_n, link.sclk, ctrl_bits},
            {21'h2, drs_pkg::CTRL_RST});
        @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(drs_pkg::RB_OFFSET_ZERO, {2'h0, drs_pkg::OFS_RST});
        end_of_test();
    end
endmodule : dac_register_readback_select_test

// ===== verification/drs_link_props.sv
`timescale 1ns/10ps
// Watches the serial link from the core clock domain, which makes sclk
module drs_link_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdi,
    input wire logic sdo
);
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Rises of sclk in the current frame; cleared while the strobe is high
    always_comb begin
        next_bit_cnt = bit_cnt;
        if (sync_n) next_bit_cnt = 5'h00;
        else if (sclk && !sclk_q) next_bit_cnt = bit_cnt + 5'h01;
    end

    // sclk is a core flop, so sampling it on core_clk sees every phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
        end else begin
            sclk_q <= sclk;
            bit_cnt <= next_bit_cnt;
        end
    end

    idle_clock_low_a: assert property (sync_n |-> !sclk)
        else $error("sclk high outside a frame");
    frame_length_a: assert property ($rose(sync_n) |-> bit_cnt == 5'h18)
        else $error("frame did not hold 24 clock rises");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase is not four cycles");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("sclk low phase too short");
    first_edge_a: assert property ($fell(sync_n) |-> !sclk [*4] ##1 sclk)
        else $error("first rise not four cycles after frame start");
    sdi_steady_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("sdi moved while sclk high");
    sdo_launch_a: assert property (!$rose(sclk) |-> $stable(sdo))
        else $error("sdo moved away from a clock rise");
    pad_zero_a: assert property (!sync_n && !sclk && bit_cnt != 5'h00 && bit_cnt <= 5'h08
        |-> !sdo)
        else $error("upper byte of readback word not zero");
    frame_gap_a: assert property ($rose(sync_n) |-> sync_n [*4])
        else $error("gap between frames too short");

    // Main scenarios
    cover property ($rose(sync_n) && bit_cnt == 5'h18);
    cover property (!sclk && sdo);
    cover property ($fell(sync_n));
endmodule : drs_link_props

// ===== verilog/drs_device.sv
`timescale 1ns/10ps
// Device end: whole module runs on the link clock made by the host
module drs_device (
    // Link and reset
    drs_link_if.dev link,
    input wire logic rst,
    // Per-channel readback request to the channel store
    output logic rb_pending,
    output logic [2:0] rb_type,
    output logic [4:0] rb_channel,
    output logic rb_chan_ok,
    input wire logic [15:0] rb_word,
    // Global register contents
    output logic [2:0] ctrl_bits,
    output logic [13:0] offset_zero,
    output logic [13:0] offset_one,
    output logic [31:0] absel
);

    // Receive shifter state
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [22:0] rx_sh;
    logic [22:0] next_rx_sh;
    logic frame_done;
    logic [23:0] frame_word;

    // Decoded fields of the completed frame
    logic [1:0] f_mode;
    logic [5:0] f_func;
    logic [15:0] f_pay;
    logic f_special;

    // Count edges and gather bits while the frame is open
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_rx_sh = rx_sh;
        frame_done = 1'b0;
        frame_word = {rx_sh, link.sdi};
        if (link.sync_n) begin
            // Sync high at an edge aborts a partial frame
            next_bit_cnt = 5'h00;
        end else begin
            next_rx_sh = {rx_sh[21:0], link.sdi};
            if (bit_cnt == drs_pkg::LAST_BIT) begin
                next_bit_cnt = 5'h00;
                frame_done = 1'b1;
            end else begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 5'h00;
            rx_sh <= 23'h000000;
        end else begin
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
        end
    end

    // Split the frame into mode, function and payload
    always_comb begin
        f_mode = frame_word[drs_pkg::MODE_HI:drs_pkg::MODE_LO];
        f_func = frame_word[drs_pkg::FUNC_HI:drs_pkg::FUNC_LO];
        f_pay = frame_word[drs_pkg::PAY_HI:0];
        f_special = (f_mode == drs_pkg::MODE_SPECIAL);
    end

    // Global registers and readback selection
    logic [8:0] sel_code;
    logic [8:0] next_sel_code;
    logic sel_valid;
    logic next_sel_valid;
    logic [2:0] next_ctrl_bits;
    logic [13:0] next_offset_zero;
    logic [13:0] next_offset_one;
    // Kept two bits wide so codes 6..9 wrap onto registers 0..3 without a borrow
    logic [1:0] ab_wr_idx;
    logic [31:0] next_absel;

    // Apply special-function writes; other modes are left to the data path
    always_comb begin
        next_sel_code = sel_code;
        next_sel_valid = sel_valid;
        next_ctrl_bits = ctrl_bits;
        next_offset_zero = offset_zero;
        next_offset_one = offset_one;
        next_absel = absel;
        ab_wr_idx = f_func[1:0] - 2'h2;
        if (frame_done) begin
            // Any completed frame consumes a pending selection
            next_sel_valid = 1'b0;
            if (f_special) begin
                unique case (f_func)
                    drs_pkg::FN_CTRL: next_ctrl_bits = f_pay[2:0];
                    drs_pkg::FN_OFFSET_ZERO: next_offset_zero = f_pay[13:0];
                    drs_pkg::FN_OFFSET_ONE: next_offset_one = f_pay[13:0];
                    drs_pkg::FN_READSEL: begin
                        // Bits 6:0 are dropped here so they cannot steer the choice
                        next_sel_code = f_pay[drs_pkg::PAY_HI:drs_pkg::SEL_LO];
                        next_sel_valid = 1'b1;
                    end
                    drs_pkg::FN_ABALL: next_absel = {4{f_pay[7:0]}};
                    default: begin
                        if (f_func >= drs_pkg::FN_ABSEL0 && f_func <= drs_pkg::FN_ABSEL3) begin
                            next_absel[{ab_wr_idx, 3'h0} +: 8] = f_pay[7:0];
                        end
                        // NOP and reserved codes change nothing
                    end
                endcase
            end
        end
    end

    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            sel_code <= 9'h000;
            sel_valid <= 1'b0;
            ctrl_bits <= drs_pkg::CTRL_RST;
            offset_zero <= drs_pkg::OFS_RST;
            offset_one <= drs_pkg::OFS_RST;
            absel <= {4{drs_pkg::ABSEL_RST}};
        end else begin
            sel_code <= next_sel_code;
            sel_valid <= next_sel_valid;
            ctrl_bits <= next_ctrl_bits;
            offset_zero <= next_offset_zero;
            offset_one <= next_offset_one;
            absel <= next_absel;
        end
    end

    // Per-channel request seen by the channel store
    logic [5:0] sel_chan;
    always_comb begin
        sel_chan = sel_code[5:0];
        rb_pending = sel_valid && !sel_code[8];
        rb_type = sel_code[8:6];
        rb_chan_ok = (sel_chan >= drs_pkg::CHAN_BASE) && (sel_chan <= drs_pkg::CHAN_LAST);
        rb_channel = 5'(sel_chan - drs_pkg::CHAN_BASE);
    end

    // Word to be returned; unknown and reserved codes read as zero
    logic [15:0] rd_value;
    logic [1:0] rd_ab_idx;
    always_comb begin
        rd_value = 16'h0000;
        rd_ab_idx = sel_code[1:0] - 2'h2;
        if (!sel_code[8]) begin
            if (rb_chan_ok && sel_code[8:6] <= drs_pkg::RB_GAINC) begin
                rd_value = rb_word;
            end
        end else begin
            unique case (sel_code)
                drs_pkg::RB_CTRL: rd_value = {13'h0000, ctrl_bits};
                drs_pkg::RB_OFFSET_ZERO: rd_value = {2'h0, offset_zero};
                drs_pkg::RB_OFFSET_ONE: rd_value = {2'h0, offset_one};
                default: begin
                    if (sel_code >= drs_pkg::RB_ABSEL0 && sel_code <= drs_pkg::RB_ABSEL3) begin
                        rd_value = {8'h00, absel[{rd_ab_idx, 3'h0} +: 8]};
                    end
                end
            endcase
        end
    end

    // Transmit shifter: loaded on the first edge of the frame after selection
    logic [23:0] tx_sh;
    logic [23:0] next_tx_sh;
    logic sdo_q;
    logic next_sdo_q;
    logic [23:0] tx_load;

    always_comb begin
        tx_load = sel_valid ? {8'h00, rd_value} : 24'h000000;
        next_tx_sh = tx_sh;
        next_sdo_q = sdo_q;
        if (!link.sync_n) begin
            if (bit_cnt == 5'h00) begin
                // MSB goes out right away, the rest wait in the shifter
                next_sdo_q = tx_load[23];
                next_tx_sh = {tx_load[22:0], 1'b0};
            end else begin
                next_sdo_q = tx_sh[23];
                next_tx_sh = {tx_sh[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            tx_sh <= 24'h000000;
            sdo_q <= 1'b0;
        end else begin
            tx_sh <= next_tx_sh;
            sdo_q <= next_sdo_q;
        end
    end

    assign link.sdo = sdo_q;

endmodule : drs_device

// ===== verilog/drs_host.sv
`timescale 1ns/10ps
// Host end: makes the link clock from core_clk by a divider
module drs_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link
    drs_link_if.host link,
    // Raw frame write
    input wire logic wr_req,
    input wire logic [23:0] wr_word,
    // Register read
    input wire logic rd_req,
    input wire logic [8:0] rd_code,
    // Status and results
    output logic busy,
    output logic done,
    output logic [23:0] rx_word,
    output logic [15:0] rd_data
);

    typedef enum logic [2:0] {
        DRS_IDLE,
        DRS_LOW,
        DRS_HIGH,
        DRS_TAIL,
        DRS_GAP
    } drs_state_t;

    // Bring the returning data into the core domain
    logic sdo_m;
    logic sdo_s;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdo_m <= 1'b0;
            sdo_s <= 1'b0;
        end else begin
            sdo_m <= link.sdo;
            sdo_s <= sdo_m;
        end
    end

    drs_state_t state;
    drs_state_t next_state;
    logic [3:0] ph_cnt;
    logic [3:0] next_ph_cnt;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [23:0] tx_sh;
    logic [23:0] next_tx_sh;
    logic [23:0] rx_sh;
    logic [23:0] next_rx_sh;
    logic nop_due;
    logic next_nop_due;
    logic is_read;
    logic next_is_read;
    logic sclk_q;
    logic next_sclk_q;
    logic sync_q;
    logic next_sync_q;
    logic next_done;
    logic [23:0] next_rx_word;
    logic [15:0] next_rd_data;
    logic phase_end;

    localparam logic [3:0] HALF_LAST = 4'(drs_pkg::SCLK_HALF_CYC - 1);
    localparam logic [3:0] GAP_LAST = 4'(drs_pkg::SYNC_GAP_CYC - 1);

    // Frame sequencer; a read is always a select frame then a NOP frame
    always_comb begin
        next_state = state;
        next_ph_cnt = ph_cnt + 4'h1;
        next_bit_cnt = bit_cnt;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_nop_due = nop_due;
        next_is_read = is_read;
        next_sclk_q = sclk_q;
        next_sync_q = sync_q;
        next_done = 1'b0;
        next_rx_word = rx_word;
        next_rd_data = rd_data;
        phase_end = (ph_cnt == HALF_LAST);
        unique case (state)
            DRS_IDLE: begin
                next_ph_cnt = 4'h0;
                next_bit_cnt = 5'h00;
                if (rd_req) begin
                    // Select frame carries the nine-bit code in payload 15:7
                    next_tx_sh = {drs_pkg::MODE_SPECIAL, drs_pkg::FN_READSEL,
                        rd_code, 7'h00};
                    next_nop_due = 1'b1;
                    next_is_read = 1'b1;
                    next_sync_q = 1'b0;
                    next_state = DRS_LOW;
                end else if (wr_req) begin
                    next_tx_sh = wr_word;
                    next_nop_due = 1'b0;
                    next_is_read = 1'b0;
                    next_sync_q = 1'b0;
                    next_state = DRS_LOW;
                end
            end
            DRS_LOW: begin
                if (phase_end) begin
                    // Data from the previous device edge has settled here
                    if (bit_cnt != 5'h00) begin
                        next_rx_sh = {rx_sh[22:0], sdo_s};
                    end
                    next_sclk_q = 1'b1;
                    next_ph_cnt = 4'h0;
                    next_state = DRS_HIGH;
                end
            end
            DRS_HIGH: begin
                if (phase_end) begin
                    next_sclk_q = 1'b0;
                    next_ph_cnt = 4'h0;
                    next_tx_sh = {tx_sh[22:0], 1'b0};
                    if (bit_cnt == drs_pkg::LAST_BIT) begin
                        next_state = DRS_TAIL;
                    end else begin
                        next_bit_cnt = bit_cnt + 5'h01;
                        next_state = DRS_LOW;
                    end
                end
            end
            DRS_TAIL: begin
                if (phase_end) begin
                    next_rx_sh = {rx_sh[22:0], sdo_s};
                    next_sync_q = 1'b1;
                    next_ph_cnt = 4'h0;
                    next_state = DRS_GAP;
                end
            end
            DRS_GAP: begin
                if (ph_cnt == GAP_LAST) begin
                    next_ph_cnt = 4'h0;
                    next_bit_cnt = 5'h00;
                    if (nop_due) begin
                        next_tx_sh = {drs_pkg::MODE_SPECIAL, drs_pkg::FN_NOP,
                            drs_pkg::NOP_PAYLOAD};
                        next_nop_due = 1'b0;
                        next_sync_q = 1'b0;
                        next_state = DRS_LOW;
                    end else begin
                        next_done = 1'b1;
                        next_rx_word = rx_sh;
                        if (is_read) begin
                            next_rd_data = rx_sh[15:0];
                        end
                        next_state = DRS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= DRS_IDLE;
            ph_cnt <= 4'h0;
            bit_cnt <= 5'h00;
            tx_sh <= 24'h000000;
            rx_sh <= 24'h000000;
            nop_due <= 1'b0;
            is_read <= 1'b0;
            sclk_q <= 1'b0;
            sync_q <= 1'b1;
            done <= 1'b0;
            rx_word <= 24'h000000;
            rd_data <= 16'h0000;
        end else begin
            state <= next_state;
            ph_cnt <= next_ph_cnt;
            bit_cnt <= next_bit_cnt;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            nop_due <= next_nop_due;
            is_read <= next_is_read;
            sclk_q <= next_sclk_q;
            sync_q <= next_sync_q;
            done <= next_done;
            rx_word <= next_rx_word;
            rd_data <= next_rd_data;
        end
    end

    // Pins come straight from flops; data is held stable across each high phase
    assign link.sclk = sclk_q;
    assign link.sync_n = sync_q;
    assign link.sdi = tx_sh[23];
    assign busy = (state != DRS_IDLE);

endmodule : drs_host
